// *** bench/pcs_card_model.sv ***
// far-side card model: read data and input acknowledge
`timescale 1ns/10ps
module pcs_card_model (
  // card pins seen from the card
  input wire logic iord_n,
  input wire logic reg_n,
  input wire logic req,
  output logic inpack_n,
  output logic [15:0] d
);
  // real data only under the read strobe, inverted filler otherwise
  assign d = iord_n ? 16'h5A3C : 16'hA5C3;
  // ack an io read, or raise a dma request when the bench asks
  assign inpack_n = !((!iord_n && reg_n) || req);
endmodule

// *** bench/pcs_strobe_monitor.sv ***
// checker for the pc card strobe controller
`timescale 1ns/10ps
module pcs_strobe_monitor (
  input wire ref_clk,
  input wire rstn,
  input wire cmd_ready_q,
  input wire [1:0] cmd_op,
  input wire cmd_a0,
  input wire cmd_wide,
  input wire cmd_last,
  input wire card_ce1_n_q,
  input wire card_ce2_n_q,
  input wire card_iord_n_q,
  input wire card_iowr_n_q,
  input wire card_reg_n_q,
  input wire card_oe_n_q,
  input wire card_we_n_q,
  input wire card_d_oe_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_no_overlap: assert property (card_iord_n_q || card_iowr_n_q)
    else $error("both strobes low");
  a_io_read: assert property (
    $fell(cmd_ready_q) && cmd_op == 2'h0 |->
    !card_iord_n_q && card_iowr_n_q) else $error("io read strobe");
  a_io_write: assert property (
    $fell(cmd_ready_q) && cmd_op == 2'h1 |->
    !card_iowr_n_q && card_iord_n_q) else $error("io write strobe");
  a_dma_tocard: assert property (
    $fell(cmd_ready_q) && cmd_op == 2'h2 |->
    !card_iowr_n_q && !card_reg_n_q) else $error("dma read strobe");
  a_dma_tohost: assert property (
    $fell(cmd_ready_q) && cmd_op == 2'h3 |->
    !card_iord_n_q && !card_reg_n_q) else $error("dma write strobe");
  a_lane_pick: assert property (
    $fell(cmd_ready_q) |->
    card_ce1_n_q == (!cmd_wide && cmd_a0) &&
    card_ce2_n_q == (!cmd_wide && !cmd_a0)) else $error("lane select");
  a_term_count: assert property (
    $fell(cmd_ready_q) && cmd_last && cmd_op[1] |->
    card_we_n_q == cmd_op[0] && card_oe_n_q == !cmd_op[0])
    else $error("terminal count");
  a_read_width: assert property (
    $fell(card_iord_n_q) |->
    !card_iord_n_q [*8] ##1 card_iord_n_q) else $error("strobe width");
  a_bus_turn: assert property (
    !card_iord_n_q |-> !card_d_oe_q) else $error("data driven under read");
  a_item_release: assert property (
    $rose(card_iord_n_q) || $rose(card_iowr_n_q) |=>
    card_ce1_n_q && card_ce2_n_q && card_reg_n_q && card_oe_n_q &&
    card_we_n_q && !card_d_oe_q) else $error("selects held after strobe");
endmodule
bind pcs_strobe pcs_strobe_monitor i_pcs_strobe_monitor (
  .ref_clk(ref_clk), .rstn(rstn), .cmd_ready_q(cmd_ready_q),
  .cmd_op(cmd_op), .cmd_a0(cmd_a0), .cmd_wide(cmd_wide),
  .cmd_last(cmd_last), .card_ce1_n_q(card_ce1_n_q),
  .card_ce2_n_q(card_ce2_n_q), .card_iord_n_q(card_iord_n_q),
  .card_iowr_n_q(card_iowr_n_q), .card_reg_n_q(card_reg_n_q),
  .card_oe_n_q(card_oe_n_q), .card_we_n_q(card_we_n_q),
  .card_d_oe_q(card_d_oe_q));

// *** bench/pcs_strobe_tb_top.sv ***
// self-checking bench for the pc card strobe controller
`timescale 1ns/10ps
module pcs_strobe_tb_top;
  logic ref_clk = 0, rstn = 0, ce = 1, cmd_valid = 0, cmd_a0 = 0;
  logic cmd_wide = 0, cmd_last = 0, wr_valid = 0, card_inpack_n, req = 0;
  logic [1:0] cmd_op = 0;
  logic [15:0] wr_data = 0, card_d_in, rd_data_q, card_d_out_q;
  wire cmd_ready_q, wr_ready, rd_valid_q, card_ce1_n_q, card_ce2_n_q;
  wire card_iord_n_q, card_iowr_n_q, card_reg_n_q, card_oe_n_q;
  wire card_we_n_q, card_d_oe_q, dma_req_q;
  int mismatches = 0, check_count = 0, i, j, n;
  always #5 ref_clk = ~ref_clk;
  pcs_strobe i_pcs_strobe (
    .ref_clk(ref_clk), .rstn(rstn), .ce(ce),
    .cmd_valid(cmd_valid), .cmd_ready_q(cmd_ready_q), .cmd_op(cmd_op),
    .cmd_a0(cmd_a0), .cmd_wide(cmd_wide), .cmd_last(cmd_last),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q),
    .card_ce1_n_q(card_ce1_n_q), .card_ce2_n_q(card_ce2_n_q),
    .card_iord_n_q(card_iord_n_q), .card_iowr_n_q(card_iowr_n_q),
    .card_reg_n_q(card_reg_n_q), .card_oe_n_q(card_oe_n_q),
    .card_we_n_q(card_we_n_q), .card_inpack_n(card_inpack_n),
    .card_d_out_q(card_d_out_q), .card_d_oe_q(card_d_oe_q),
    .card_d_in(card_d_in), .dma_req_q(dma_req_q));
  pcs_card_model i_pcs_card_model (.iord_n(card_iord_n_q),
    .reg_n(card_reg_n_q), .req(req), .inpack_n(card_inpack_n),
    .d(card_d_in));
  task summarize;
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value at %0t: %h vs %h", $time, s, e);
    end
  endtask
  // bounded wait for the ready level, sampled at the edge
  task w_rdy(input logic v);
    for (i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      if (cmd_ready_q === v) break;
    end
    if (i == 40) begin
      mismatches++;
      summarize;
    end
  endtask
  // one command, pins checked in the second strobe cycle
  task run(input logic [1:0] op, input logic a0, w, l, input logic [6:0] p);
    w_rdy(1);
    cmd_op <= op;
    cmd_a0 <= a0;
    cmd_wide <= w;
    cmd_last <= l;
    cmd_valid <= 1;
    w_rdy(0);
    cmd_valid <= 0;
    #1 chk({card_ce1_n_q, card_ce2_n_q, card_iord_n_q, card_iowr_n_q,
      card_reg_n_q, card_oe_n_q, card_we_n_q}, p);
    // card-to-host commands: io read and dma write both return data
    if (op == 2'h0 || op == 2'h3) begin
      for (j = 0; j < 20 && rd_valid_q !== 1'b1; j++) @(posedge ref_clk) #1;
      chk(rd_valid_q, 1);
      chk(rd_data_q, 16'hA5C3);
    end
  endtask
  task s_reads;
    run(2'h0, 0, 0, 0, 7'b0101111);
    run(2'h0, 1, 0, 0, 7'b1001111);
    run(2'h0, 0, 1, 0, 7'b0001111);
  endtask
  task s_dma_out;
    run(2'h3, 0, 1, 1, 7'b0001001);
    run(2'h3, 0, 1, 0, 7'b0001011);
  endtask
  // fill until refused, then drain by writes, last one a dma item
  task s_fifo;
    n = 0;
    @(posedge ref_clk);
    wr_valid <= 1;
    wr_data <= 16'h1000;
    repeat (20) begin
      @(posedge ref_clk);
      if (wr_ready) n++;
      wr_data <= 16'h1000 + n[15:0];
    end
    wr_valid <= 0;
    chk(n[15:0], 16'h0010);
    chk(wr_ready, 0);
    for (n = 0; n < 16; n++) begin
      run(n == 15 ? 2'h2 : 2'h1, n[0], 0, n == 15,
        {n[0], !n[0], 2'b10, n != 15, 1'b1, n != 15});
      chk(card_d_out_q, 16'h1000 + n[15:0]);
      chk(card_d_oe_q, 1);
    end
    chk(wr_ready, 1);
  endtask
  // clock enable low freezes the synchroniser, then the request shows
  task s_req;
    @(posedge ref_clk);
    ce <= 0;
    req <= 1;
    repeat (4) @(posedge ref_clk);
    chk(dma_req_q, 0);
    ce <= 1;
    repeat (4) @(posedge ref_clk);
    chk(dma_req_q, 1);
    req <= 0;
    repeat (4) @(posedge ref_clk);
    chk(dma_req_q, 0);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1;
    s_reads;
    s_fifo;
    s_dma_out;
    s_req;
    summarize;
  end
endmodule

// *** inc/pcs_regs.vh ***
// timing and encoding constants for the pc card strobe controller
`ifndef PCS_REGS_VH
`define PCS_REGS_VH
// strobe low time in ns and derived cycles at 100 mhz (least time, round up)
`define PCS_CLK_NS 10
`define PCS_STROBE_NS 80
`define PCS_STROBE_CYC ((`PCS_STROBE_NS + `PCS_CLK_NS - 1) / `PCS_CLK_NS)
// command codes
`define PCS_CMD_IORD 2'h0
`define PCS_CMD_IOWR 2'h1
`define PCS_CMD_DMA_RD 2'h2
`define PCS_CMD_DMA_WR 2'h3
// fifo shape
`define PCS_FIFO_W 16
`define PCS_FIFO_D 16
`define PCS_FIFO_AW 4
`endif

// *** verilog/pcs_strobe.v ***
// pc card i/o and dma strobe controller with write-data fifo
// How it works
// - ce1 low selects even, ce2 odd byte
// - io read asserts read strobe
// - dma card-to-host uses read strobe
// - io write drives write strobe low
// - dma host-to-card uses write strobe
// - reg low acknowledges every dma item
// - terminal count on we (read) / oe (write)
`timescale 1ns/10ps
`include "pcs_regs.vh"

////////////////////////////////////////////////////////////////////////////
// simple flip-flop fifo, valid/ready on both sides
module pcs_fifo #(
  parameter W = `PCS_FIFO_W,
  parameter D = `PCS_FIFO_D,
  parameter AW = `PCS_FIFO_AW
) (
  // clocking
  input wire ref_clk,
  input wire rstn,
  input wire ce,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_q [0:D-1]; // storage
  reg [AW-1:0] wp_q; // write index
  reg [AW-1:0] rp_q; // read index
  reg [AW:0] cnt_q; // fill level
  reg [AW:0] cnt_d; // next fill level
  reg in_ready_q; // room flag, a flop so the top's ready port is registered
  wire push;
  wire pop;
  assign in_ready = in_ready_q;
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // next fill level; the room flag is computed from it one edge early
  always @* begin
    cnt_d = cnt_q;
    if (push & ~pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop & ~push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end
  // pointers and level
  always @(posedge ref_clk) begin
    if (!rstn) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      in_ready_q <= 1'b1;
    end else if (ce) begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q <= wp_q + 1'b1;
      end
      if (pop)
        rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_d;
      // full when the next level reaches the depth
      in_ready_q <= (cnt_d != D[AW:0]);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// top: one socket, host cycles and dma items
module pcs_strobe (
  // clocking
  input wire ref_clk,
  input wire rstn,
  input wire ce,
  // host command port
  input wire cmd_valid,
  output reg cmd_ready_q,
  input wire [1:0] cmd_op,
  input wire cmd_a0,
  input wire cmd_wide,
  input wire cmd_last,
  // host write data into fifo
  input wire wr_valid,
  output wire wr_ready,
  input wire [15:0] wr_data,
  // host read data out
  output reg rd_valid_q,
  output reg [15:0] rd_data_q,
  // card pins
  output reg card_ce1_n_q,
  output reg card_ce2_n_q,
  output reg card_iord_n_q,
  output reg card_iowr_n_q,
  output reg card_reg_n_q,
  output reg card_oe_n_q,
  output reg card_we_n_q,
  input wire card_inpack_n,
  output reg [15:0] card_d_out_q,
  output reg card_d_oe_q,
  input wire [15:0] card_d_in,
  // dma request seen from card
  output reg dma_req_q
);
  localparam ST_IDLE = 2'h0;
  localparam ST_STRB = 2'h1;
  localparam ST_DONE = 2'h2;
  localparam [31:0] STROBE_CYC_W = `PCS_STROBE_CYC; // full-width count
  localparam [3:0] STROBE_CYC = STROBE_CYC_W[3:0]; // cut to the timer

  reg [1:0] st_q; // controller state
  reg [3:0] tmr_q; // strobe timer
  reg [1:0] op_q; // latched command
  reg inpack_s1_q; // sync stage 1
  reg inpack_s2_q; // sync stage 2
  reg [15:0] din_s1_q; // data sync stage 1
  reg [15:0] din_s2_q; // data sync stage 2
  wire f_valid;
  wire [15:0] f_data;
  reg f_pop;

  // is this command a card-bound write
  function is_write;
    input [1:0] op;
    begin
      is_write = (op == `PCS_CMD_IOWR) || (op == `PCS_CMD_DMA_RD);
    end
  endfunction

  // write data buffered so the host can run ahead of the card
  pcs_fifo #(.W(16), .D(`PCS_FIFO_D), .AW(`PCS_FIFO_AW)) u_fifo (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: pins are async to ref_clk
  always @(posedge ref_clk) begin
    if (!rstn) begin
      inpack_s1_q <= 1'b1;
      inpack_s2_q <= 1'b1;
      din_s1_q <= 16'h0000;
      din_s2_q <= 16'h0000;
    end else if (ce) begin
      inpack_s1_q <= card_inpack_n;
      inpack_s2_q <= inpack_s1_q;
      din_s1_q <= card_d_in;
      din_s2_q <= din_s1_q;
    end
  end

  // fifo pop only when a write strobe starts with data present
  always @* begin
    f_pop = ce && (st_q == ST_IDLE) && cmd_valid && cmd_ready_q &&
      is_write(cmd_op) && f_valid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequencer; one strobe at a time keeps rd/wr exclusive
  always @(posedge ref_clk) begin
    if (!rstn) begin
      st_q <= ST_IDLE;
      tmr_q <= 4'h0;
      op_q <= 2'h0;
      cmd_ready_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= 16'h0000;
      card_ce1_n_q <= 1'b1;
      card_ce2_n_q <= 1'b1;
      card_iord_n_q <= 1'b1;
      card_iowr_n_q <= 1'b1;
      card_reg_n_q <= 1'b1;
      card_oe_n_q <= 1'b1;
      card_we_n_q <= 1'b1;
      card_d_out_q <= 16'h0000;
      card_d_oe_q <= 1'b0;
      dma_req_q <= 1'b0;
    end else if (ce) begin
      rd_valid_q <= 1'b0;
      dma_req_q <= ~inpack_s2_q;
      case (st_q)
        ST_IDLE: begin
          cmd_ready_q <= 1'b1;
          // write commands wait for fifo data
          if (cmd_valid && cmd_ready_q &&
              (!is_write(cmd_op) || f_valid)) begin
            cmd_ready_q <= 1'b0;
            op_q <= cmd_op;
            tmr_q <= STROBE_CYC;
            // even lane ce1, odd lane ce2, both for a word
            card_ce1_n_q <= ~(cmd_wide | ~cmd_a0);
            card_ce2_n_q <= ~(cmd_wide | cmd_a0);
            // dma acknowledge held for the item
            card_reg_n_q <= ~cmd_op[1];
            // terminal count on last item
            card_we_n_q <= ~(cmd_last && cmd_op == `PCS_CMD_DMA_RD);
            card_oe_n_q <= ~(cmd_last && cmd_op == `PCS_CMD_DMA_WR);
            if (is_write(cmd_op)) begin
              card_iowr_n_q <= 1'b0;
              card_d_out_q <= f_data;
              card_d_oe_q <= 1'b1;
            end else begin
              card_iord_n_q <= 1'b0;
            end
            st_q <= ST_STRB;
          end
        end
        ST_STRB: begin
          if (tmr_q == 4'h1) begin
            // sample card data just before the strobe rises
            if (!is_write(op_q)) begin
              rd_data_q <= din_s2_q;
              rd_valid_q <= 1'b1;
            end
            card_iord_n_q <= 1'b1;
            card_iowr_n_q <= 1'b1;
            st_q <= ST_DONE;
          end
          tmr_q <= tmr_q - 4'h1;
        end
        ST_DONE: begin
          // release selects a cycle after the strobe for hold
          card_ce1_n_q <= 1'b1;
          card_ce2_n_q <= 1'b1;
          card_reg_n_q <= 1'b1;
          card_oe_n_q <= 1'b1;
          card_we_n_q <= 1'b1;
          card_d_oe_q <= 1'b0;
          st_q <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
